// File: core/crps_consts.svh
// Register offsets, field layout and reset values for the reset and power-on sequencer
`ifndef CRPS_CONSTS_SVH
`define CRPS_CONSTS_SVH
`define CRPS_OFF_FORCE_ON 5'h00
`define CRPS_OFF_FORCE_OFF 5'h04
`define CRPS_OFF_WD_SELECT 5'h08
`define CRPS_OFF_STAGE_READY 5'h0c
`define CRPS_OFF_CHIP_STATUS 5'h10
`define CRPS_OFF_CHIP_CLEAR 5'h14
`define CRPS_NUM_STAGES 17
`define CRPS_STAGE_ROSC 0
`define CRPS_STAGE_XOSC 1
`define CRPS_STAGE_PROC0 15
`define CRPS_STAGE_PROC1 16
`define CRPS_BIT_POWER 0
`define CRPS_BIT_PIN 1
`define CRPS_BIT_DEBUG 2
`define CRPS_BIT_RECOVERY 3
`define CRPS_ROSC_EDGES 16'h0400
`define CRPS_RESP_OKAY 2'b00
`define CRPS_RESP_SLVERR 2'b10
`define CRPS_ZERO32 32'h0000_0000
`endif

// File: core/crps_pkg.sv
// Types for the reset and power-on sequencer
package crps_pkg;
   typedef enum logic [1:0] {
      CRPS_CAUSE_NONE,
      CRPS_CAUSE_POWER,
      CRPS_CAUSE_PIN,
      CRPS_CAUSE_DEBUG
   } crps_cause_t;
endpackage

// File: core/crps_sequencer.sv
// Chip-level reset combiner and power-on sequencer with AXI4-Lite registers
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/100ps
`include "crps_consts.svh"

// Behaviour
// - Run pin low holds whole chip in reset whatever the supplies say.
// - Run pin high releases chip reset at once if other sources released.
// - Regulator input supply low re-initialises the power-on reset block.
// - Debug port reset resets chip and sets persistent recovery flag.
// - Record latest chip reset cause: power, pin or debug flag.
// - At most one of the three cause flags is set.
// - Release stages in turn, waiting on each stage's done acknowledge except the crystal oscillator stage's.
// - Sequencer and early reset leave reset together once supply and pin good.
// - Early reset is not reasserted when the sequencer restarts.
// - Ring oscillator done only after ripple counter sees enough edges.
// - Crystal oscillator stage released without starting it, done at once.
// - Clock generators follow oscillators; reference from ring, system from reference.
// - Then reset controller, chip regs, flash, memories, fabric, processors.
// - Chip status register reset only by chip-level reset.
// - Processor stage releases both processor cores.
// - Software can override the sequencer and observe its status.
// - Watchdog restarts selected stages and every later stage; selecting only the second core's stage restarts nothing.
// - Watchdog select bit one marks the stage for watchdog reset.
// - Force-on holds stage out of reset; force-off forces it into reset.
// - Read-only done status reports per-stage readiness.
module crps_sequencer #(
   parameter int NUM_STAGES = `CRPS_NUM_STAGES,
   parameter logic [15:0] ROSC_EDGES = `CRPS_ROSC_EDGES
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic run_pin,
   input wire logic power_on_good,
   input wire logic brown_out_good,
   input wire logic regulator_input_supply_good,
   input wire logic debug_restart,
   input wire logic watchdog_fire,
   input wire logic [NUM_STAGES-1:0] stage_done,
   output logic por_reinit,
   output logic chip_reset_n,
   output logic debug_port_reset_n,
   output logic early_reset_n,
   output logic [NUM_STAGES-1:0] stage_reset_n,
   output logic rosc_enable,
   output logic xosc_enable,
   output logic ref_clk_from_rosc,
   output logic sys_clk_from_ref,
   output logic last_reset_power,
   output logic last_reset_pin,
   output logic last_reset_debug,
   output logic debug_recovery_flag,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   // ==========================================================
   // Reset combining
   logic power_ok;
   logic chip_ok;
   logic seq_run;
   crps_pkg::crps_cause_t cause;
   logic [NUM_STAGES-1:0] force_stage_on;
   logic [NUM_STAGES-1:0] force_stage_off;
   logic [NUM_STAGES-1:0] watchdog_stage_select;
   logic [NUM_STAGES-1:0] seq_release;
   logic [NUM_STAGES-1:0] done_chain;
   logic [NUM_STAGES-1:0] wd_hold;
   logic [15:0] rosc_count;
   logic rosc_done;
   logic status_clear;

   assign power_ok = power_on_good & brown_out_good & regulator_input_supply_good;
   assign por_reinit = ~regulator_input_supply_good;
   assign chip_ok = aresetn & power_ok & run_pin;
   assign debug_port_reset_n = chip_ok;
   assign chip_reset_n = chip_ok & ~debug_restart;

   // Sequencer and early reset leave reset together
   always_ff @(posedge aclk) begin
      if (!chip_reset_n) begin
         seq_run <= 1'b0;
         early_reset_n <= 1'b0;
      end else begin
         seq_run <= 1'b1;
         early_reset_n <= 1'b1;
      end
   end

   // ==========================================================
   // Reset cause recording
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cause <= crps_pkg::CRPS_CAUSE_POWER;
      end else if (!power_ok) begin
         cause <= crps_pkg::CRPS_CAUSE_POWER;
      end else if (!run_pin) begin
         cause <= crps_pkg::CRPS_CAUSE_PIN;
      end else if (debug_restart) begin
         cause <= crps_pkg::CRPS_CAUSE_DEBUG;
      end
   end
   assign last_reset_power = (cause == crps_pkg::CRPS_CAUSE_POWER);
   assign last_reset_pin = (cause == crps_pkg::CRPS_CAUSE_PIN);
   assign last_reset_debug = (cause == crps_pkg::CRPS_CAUSE_DEBUG);

   // Recovery flag: reset by chip-level reset only, set wins over clear
   always_ff @(posedge aclk) begin
      if (!chip_ok) begin
         debug_recovery_flag <= 1'b0;
      end else if (debug_restart) begin
         debug_recovery_flag <= 1'b1;
      end else if (status_clear) begin
         debug_recovery_flag <= 1'b0;
      end
   end

   // ==========================================================
   // Ring oscillator stability counter
   always_ff @(posedge aclk) begin
      if (!seq_run || !stage_reset_n[`CRPS_STAGE_ROSC]) begin
         rosc_count <= 16'h0000;
      end else if (rosc_count != ROSC_EDGES) begin
         rosc_count <= rosc_count + 16'h0001;
      end
   end
   assign rosc_done = (rosc_count == ROSC_EDGES);
   assign rosc_enable = stage_reset_n[`CRPS_STAGE_ROSC];
   assign xosc_enable = 1'b0;
   assign ref_clk_from_rosc = 1'b1;
   assign sys_clk_from_ref = 1'b1;

   // ==========================================================
   // Stage chain, order by bit index
   genvar gi;
   generate
      for (gi = 0; gi < NUM_STAGES; gi++) begin : g_stage
         logic own_done;
         if (gi == `CRPS_STAGE_ROSC) begin : g_rosc
            assign own_done = rosc_done & stage_done[gi];
         end else if (gi == `CRPS_STAGE_XOSC) begin : g_xosc
            assign own_done = stage_reset_n[gi];
         end else begin : g_other
            assign own_done = stage_done[gi];
         end
         if (gi == 0) begin : g_first
            assign seq_release[gi] = seq_run & ~wd_hold[gi];
         end else begin : g_next
            assign seq_release[gi] = seq_run & done_chain[gi-1] & ~wd_hold[gi];
         end
         assign done_chain[gi] = own_done & stage_reset_n[gi];
         if (gi == `CRPS_STAGE_PROC1) begin : g_proc1
            assign stage_reset_n[gi] = chip_reset_n & ~force_stage_off[gi] &
               (force_stage_on[gi] | seq_release[gi] |
               (seq_release[`CRPS_STAGE_PROC0] & ~force_stage_off[`CRPS_STAGE_PROC0]));
         end else begin : g_rst
            assign stage_reset_n[gi] = chip_reset_n & ~force_stage_off[gi] &
               (force_stage_on[gi] | seq_release[gi]);
         end
      end
   endgenerate

   // Watchdog restart holds selected stages for one cycle
   always_ff @(posedge aclk) begin
      if (!chip_reset_n) begin
         wd_hold <= '0;
      end else if (watchdog_fire) begin
         wd_hold <= watchdog_stage_select;
      end else begin
         wd_hold <= '0;
      end
   end

   // ==========================================================
   // AXI4-Lite slave
   logic aw_held;
   logic w_held;
   logic [4:0] aw_off;
   logic [31:0] w_data;
   logic aw_map;
   logic ar_map;
   logic [31:0] rd_value;
   logic [4:0] ar_off;

   assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
   assign s_axi_wready = ~w_held & ~s_axi_bvalid;
   assign s_axi_arready = ~s_axi_rvalid;
   assign ar_off = s_axi_araddr[4:0];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         aw_off <= 5'h00;
         aw_map <= 1'b0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held <= 1'b1;
         aw_off <= s_axi_awaddr[4:0];
         aw_map <= (s_axi_awaddr[31:5] == 27'h000_0000) &&
            (s_axi_awaddr[4:0] <= 5'h14) && (s_axi_awaddr[1:0] == 2'b00);
      end else if (aw_held && w_held) begin
         aw_held <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held <= 1'b0;
         w_data <= `CRPS_ZERO32;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held <= 1'b1;
         w_data <= s_axi_wdata & {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
            {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
      end else if (aw_held && w_held) begin
         w_held <= 1'b0;
      end
   end

   // Write commit and registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         force_stage_on <= '0;
         force_stage_off <= '0;
         watchdog_stage_select <= '0;
         status_clear <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `CRPS_RESP_OKAY;
      end else begin
         status_clear <= 1'b0;
         if (aw_held && w_held) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= aw_map ? `CRPS_RESP_OKAY : `CRPS_RESP_SLVERR;
            if (aw_map) begin
               unique case (aw_off)
                  `CRPS_OFF_FORCE_ON: force_stage_on <= w_data[NUM_STAGES-1:0];
                  `CRPS_OFF_FORCE_OFF: force_stage_off <= w_data[NUM_STAGES-1:0];
                  `CRPS_OFF_WD_SELECT: watchdog_stage_select <= w_data[NUM_STAGES-1:0];
                  `CRPS_OFF_CHIP_STATUS: status_clear <= w_data[`CRPS_BIT_RECOVERY];
                  default: status_clear <= 1'b0;
               endcase
            end
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end
   // Read data
   always_comb begin
      rd_value = `CRPS_ZERO32;
      unique case (ar_off)
         `CRPS_OFF_FORCE_ON: rd_value[NUM_STAGES-1:0] = force_stage_on;
         `CRPS_OFF_FORCE_OFF: rd_value[NUM_STAGES-1:0] = force_stage_off;
         `CRPS_OFF_WD_SELECT: rd_value[NUM_STAGES-1:0] = watchdog_stage_select;
         `CRPS_OFF_STAGE_READY: rd_value[NUM_STAGES-1:0] = done_chain;
         default: begin
            rd_value[`CRPS_BIT_POWER] = last_reset_power;
            rd_value[`CRPS_BIT_PIN] = last_reset_pin;
            rd_value[`CRPS_BIT_DEBUG] = last_reset_debug;
            rd_value[`CRPS_BIT_RECOVERY] = debug_recovery_flag;
         end
      endcase
   end
   assign ar_map = (s_axi_araddr[31:5] == 27'h000_0000) &&
      (s_axi_araddr[4:0] <= 5'h10) && (s_axi_araddr[1:0] == 2'b00);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= `CRPS_ZERO32;
         s_axi_rresp <= `CRPS_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= ar_map ? rd_value : `CRPS_ZERO32;
         s_axi_rresp <= ar_map ? `CRPS_RESP_OKAY : `CRPS_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule

// File: verification/crps_sequencer_asserts.sv
// Checker for the reset and power-on sequencer
`timescale 1ns/100ps
module crps_sequencer_asserts #(
   parameter int NUM_STAGES = 17
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic run_pin,
   input wire logic power_on_good,
   input wire logic brown_out_good,
   input wire logic regulator_input_supply_good,
   input wire logic debug_restart,
   input wire logic watchdog_fire,
   input wire logic [NUM_STAGES-1:0] stage_done,
   input wire logic por_reinit,
   input wire logic chip_reset_n,
   input wire logic early_reset_n,
   input wire logic [NUM_STAGES-1:0] stage_reset_n,
   input wire logic xosc_enable,
   input wire logic last_reset_power,
   input wire logic last_reset_pin,
   input wire logic last_reset_debug,
   input wire logic debug_recovery_flag
);
   // ==========
   // Properties
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_run_holds: assert property (!run_pin |-> !chip_reset_n)
      else $error("Chip reset free with run pin low");
   a_run_frees: assert property ((power_on_good && brown_out_good && run_pin
      && regulator_input_supply_good
      && !debug_restart) |-> chip_reset_n) else $error("Chip reset held");
   a_vin_reinit: assert property (por_reinit != regulator_input_supply_good)
      else $error("Power-on reinit wrong");
   a_debug_flag: assert property (debug_restart |-> !chip_reset_n ##1 debug_recovery_flag)
      else $error("Debug reset or flag missing");
   a_cause_one: assert property ($onehot0({last_reset_power, last_reset_pin,
      last_reset_debug})) else $error("Several cause flags");
   a_early_free: assert property (chip_reset_n ##1 chip_reset_n |-> early_reset_n)
      else $error("Early reset held");
   a_early_keep: assert property (early_reset_n && watchdog_fire |=> early_reset_n)
      else $error("Early reset on restart");
   a_rosc_wait: assert property ($rose(stage_reset_n[1]) |-> $past(stage_reset_n[0], 3))
      else $error("Oscillator stage done too soon");
   a_xosc_idle: assert property (!xosc_enable)
      else $error("Crystal oscillator started");
   a_both_cores: assert property ($rose(stage_reset_n[15]) |-> stage_reset_n[16])
      else $error("Second core kept in reset");
   a_xosc_next: assert property ($rose(stage_reset_n[2]) |-> stage_reset_n[1])
      else $error("Clock stage released before crystal stage");
   for (genvar i = 3; i < 16; i++) begin : g_ord
      a_stage_order: assert property ($rose(stage_reset_n[i]) |-> stage_done[i-1])
         else $error("Stage released before previous done");
   end
endmodule

bind crps_sequencer crps_sequencer_asserts #(.NUM_STAGES(NUM_STAGES)) asserts_u (
   .aclk, .aresetn, .run_pin, .power_on_good, .brown_out_good,
   .regulator_input_supply_good, .debug_restart, .watchdog_fire, .stage_done,
   .por_reinit, .chip_reset_n, .early_reset_n, .stage_reset_n, .xosc_enable,
   .last_reset_power, .last_reset_pin, .last_reset_debug, .debug_recovery_flag
);

// File: verification/crps_sequencer_tb_top.sv
// Testbench for the reset and power-on sequencer
`timescale 1ns/100ps
module crps_sequencer_tb_top;
   logic aclk, aresetn, run_pin, power_on_good, brown_out_good, regulator_input_supply_good;
   logic debug_restart, watchdog_fire, chip_reset_n, early_reset_n;
   logic last_reset_power, last_reset_pin, last_reset_debug, debug_recovery_flag;
   logic [16:0] stage_done, stage_reset_n, seen;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd, d;
   logic [3:0] s_axi_wstrb;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   int num_errors, cmp_count;
   crps_sequencer #(.ROSC_EDGES(16'h0004)) dut_u (
      .aclk, .aresetn, .run_pin, .power_on_good, .brown_out_good,
      .regulator_input_supply_good, .debug_restart, .watchdog_fire, .stage_done,
      .por_reinit(), .chip_reset_n, .debug_port_reset_n(), .early_reset_n, .stage_reset_n,
      .rosc_enable(), .xosc_enable(), .ref_clk_from_rosc(), .sys_clk_from_ref(),
      .last_reset_power, .last_reset_pin, .last_reset_debug, .debug_recovery_flag,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready
   );
   crps_stage_model #(.N(17)) model_u (.aclk, .stage_reset_n, .stage_done);
   // ==========
   // Tasks
   task chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task wr(input logic [31:0] a, input logic [31:0] v, output logic [1:0] r);
      logic ga, gw;
      ga = 0;
      gw = 0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      while (!(ga && gw)) begin
         @(posedge aclk);
         if (!ga && s_axi_awready) begin
            ga = 1;
            s_axi_awvalid <= 0;
         end
         if (!gw && s_axi_wready) begin
            gw = 1;
            s_axi_wvalid <= 0;
         end
      end
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
      r = s_axi_bresp;
      s_axi_bready <= 0;
   endtask
   task rd32(input logic [31:0] a, output logic [31:0] v, output logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 0;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      v = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 0;
   endtask
   task wait_up;
      for (int n = 0; n < 400 && stage_done !== 17'h1_ffff; n++) @(posedge aclk);
   endtask
   task watch(input int n);
      seen = 0;
      repeat (n) begin
         @(posedge aclk);
         seen = seen | ~stage_reset_n;
      end
   endtask
   task status(input logic [31:0] exp);
      wait_up();
      rd32(32'h10, rd, rs);
      chk(rd, exp);
   endtask
   task end_of_test;
      $display("Comparisons %0d, errors %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // ==========
   // Stimulus
   initial begin
      aclk = 0;
      forever #2 aclk = ~aclk;
   end
   initial begin
      #200000;
      num_errors++;
      end_of_test();
   end
   initial begin
      {aresetn, debug_restart, watchdog_fire, s_axi_awvalid, s_axi_wvalid} = '0;
      {s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
      {run_pin, power_on_good, brown_out_good, regulator_input_supply_good} = 4'hf;
      s_axi_wdata = '0;
      s_axi_wstrb = 4'hf;
      d = $urandom(32'h509d);
      repeat (8) @(posedge aclk);
      aresetn <= 1;
      status(32'h1);
      for (int k = 0; k < 12; k += 4) begin
         rd32(k, rd, rs);
         chk(rd, 32'h0);
      end
      rd32(32'hc, rd, rs);
      chk(rd, 32'h0001_ffff);
      wr(32'hc, 32'h0, rs);
      rd32(32'hc, rd, rs);
      chk(rd, 32'h0001_ffff);
      rd32(32'h20, rd, rs);
      chk({30'h0, rs}, 32'h2);
      chk(rd, 32'h0);
      repeat (4) begin
         d = $urandom;
         wr(32'h8, d, rs);
         rd32(32'h8, rd, rs);
         chk(rd, d & 32'h0001_ffff);
      end
      wr(32'h8, 32'h10, rs);
      debug_restart <= 1;
      repeat (3) @(posedge aclk);
      debug_restart <= 0;
      status(32'hc);
      watchdog_fire <= 1;
      @(posedge aclk);
      watchdog_fire <= 0;
      watch(40);
      chk(seen, 17'h1_fff0);
      status(32'hc);
      wr(32'h0, 32'h0001_0000, rs);
      wr(32'h4, 32'h0000_1000, rs);
      watch(40);
      chk(seen, 17'h0_f000);
      wr(32'h4, 32'h0, rs);
      wr(32'h0, 32'h0, rs);
      wait_up();
      chk(stage_reset_n, 17'h1_ffff);
      wr(32'h10, 32'h8, rs);
      status(32'h4);
      run_pin <= 0;
      repeat (3) @(posedge aclk);
      run_pin <= 1;
      status(32'h2);
      regulator_input_supply_good <= 0;
      power_on_good <= 0;
      repeat (3) @(posedge aclk);
      regulator_input_supply_good <= 1;
      power_on_good <= 1;
      status(32'h1);
      end_of_test();
   end
endmodule

// File: verification/crps_stage_model.sv
// Sequenced blocks answering with done acknowledges
`timescale 1ns/100ps
module crps_stage_model #(
   parameter int N = 17
) (
   input wire logic aclk,
   input wire logic [N-1:0] stage_reset_n,
   output logic [N-1:0] stage_done
);
   int cnt [N];
   always @(posedge aclk) begin
      for (int i = 0; i < N; i++) begin
         if (!stage_reset_n[i]) begin
            cnt[i] <= 0;
            stage_done[i] <= 1'b0;
         end else if (cnt[i] >= i % 4) begin
            stage_done[i] <= 1'b1;
         end else begin
            cnt[i] <= cnt[i] + 1;
         end
      end
   end
endmodule
